// file: src/adcseq_pkg.sv
// constants and types shared by the converter acquisition sequencer
package adcseq_pkg;

  // converter geometry
  localparam int RESULT_BITS    = 10;
  localparam int PORT_BITS      = 8;
  localparam int CHANNEL_BITS   = 4;
  localparam int SEL_BITS       = 3;

  // timing counts, in conversion bit periods unless stated
  localparam logic [4:0] CONV_PERIODS     = 5'd11;
  localparam logic [4:0] HOLDOFF_PERIODS  = 5'd2;
  localparam logic [4:0] DISCHARGE_PERIODS = 5'd1;
  // one instruction cycle is four oscillator clocks
  localparam logic [2:0] INSTR_CLOCKS     = 3'd4;

  // acquisition select: automatic period per code, code 000 is manual
  localparam logic [2:0] ACQ_MANUAL       = 3'h0;
  localparam logic [2:0] ACQ_SEL_RESET    = 3'h0;
  localparam logic [2:0] CLK_SEL_RESET    = 3'h0;

  // conversion clock select: low two bits 11 pick the internal rc clock
  localparam logic [1:0] CLK_RC_CODE      = 2'h3;

  // first trial code of the successive approximation
  localparam logic [9:0] SAR_FIRST_TRIAL  = 10'h200;

  // port analog configuration after reset, chosen by the strap
  localparam logic [7:0] PORT_CFG_ANALOG  = 8'hFF;
  localparam logic [7:0] PORT_CFG_DIGITAL = 8'h00;
  localparam logic [9:0] RESULT_RESET     = 10'h000;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_DISCHARGE,
    ST_SAMPLE,
    ST_ACQUIRE,
    ST_DELAY,
    ST_CONVERT,
    ST_HOLDOFF
  } adcseq_state_type;

endpackage : adcseq_pkg

// file: src/adcseq_top.sv
// acquisition, conversion timing and flag logic of the 10-bit converter
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - 3-bit field programs 2..20 period acquisition
// - nonzero select: sample, then convert automatically
// - select 000 converts at once; reset default
// - completion clears start, sets flag, resamples
// - no acquisition-ended or conversion-started status
// - conversion lasts eleven bit periods; first may be short in manual mode
// - clock select maps to 2..64 clocks or rc
// - manual mode delays start one instruction cycle
// - sample selected pin whatever its direction
// - analog-configured pins read as zero
// - strap chooses port analog config reset value
// - clearing start mid-conversion aborts it
// - abort leaves result registers unchanged
// - two-period holdoff then acquisition restarts
// - discharge capacitor array before every sample
// - select 010 gives four period acquisition
// - completion loads result high and low
// - reset turns converter off, aborts conversion
// - trigger ignored while converter is off
module adcseq_top (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_converter_on_bit,
  input  wire logic       i_start_set,
  input  wire logic       i_start_clear,
  input  wire logic       i_special_trigger,
  input  wire logic [2:0] i_acquisition_time_select,
  input  wire logic [2:0] i_conversion_clock_select,
  input  wire logic [3:0] i_channel_select,
  input  wire logic       i_internal_rc_clock,
  input  wire logic       i_comparator,
  input  wire logic       i_complete_clear,
  input  wire logic       i_result_write,
  input  wire logic [9:0] i_result_wdata,
  input  wire logic       i_portb_analog_reset_select,
  input  wire logic       i_port_cfg_write,
  input  wire logic [7:0] i_port_cfg_wdata,
  input  wire logic [7:0] i_port_pins,
  output logic            o_start_flag,
  output logic            o_conversion_complete_flag,
  output logic [7:0]      o_result_high_reg,
  output logic [7:0]      o_result_low_reg,
  output logic [7:0]      o_port_analog_config_bits,
  output logic [7:0]      o_port_read,
  output logic [3:0]      o_mux_channel,
  output logic            o_sample_switch,
  output logic            o_discharge,
  output logic [9:0]      o_dac_code
);

  adcseq_pkg::adcseq_state_type state_ff;

  logic [6:0] div_cnt_ff;
  logic       rc_meta_ff, rc_sync_ff, rc_last_ff;
  logic       cmp_meta_ff, cmp_sync_ff;
  logic [7:0] pin_meta_ff, pin_sync_ff;
  logic       tad_tick;
  logic [4:0] phase_cnt_ff;
  logic [2:0] delay_cnt_ff;
  logic       go_ff;
  logic       complete_ff;
  logic [9:0] sar_ff;
  logic [9:0] mask_ff;
  logic [9:0] result_ff;
  logic       cfg_loaded_ff;
  logic [7:0] port_cfg_ff;
  logic [7:0] port_read_ff;
  logic [3:0] channel_ff;
  logic       start_req;
  logic       busy;
  logic       conv_done;
  logic       abort;
  logic [9:0] sar_decided;

  // bit period in oscillator clocks for a clock select code
  function automatic logic [6:0] clk_div_periods(input logic [2:0] sel);
    case (sel)
      3'h0:    clk_div_periods = 7'd2;
      3'h4:    clk_div_periods = 7'd4;
      3'h1:    clk_div_periods = 7'd8;
      3'h5:    clk_div_periods = 7'd16;
      3'h2:    clk_div_periods = 7'd32;
      3'h6:    clk_div_periods = 7'd64;
      default: clk_div_periods = 7'd2;
    endcase
  endfunction

  // automatic acquisition length in bit periods, zero for manual
  function automatic logic [4:0] acq_periods(input logic [2:0] sel);
    case (sel)
      3'h1:    acq_periods = 5'd2;
      3'h2:    acq_periods = 5'd4;
      3'h3:    acq_periods = 5'd6;
      3'h4:    acq_periods = 5'd8;
      3'h5:    acq_periods = 5'd12;
      3'h6:    acq_periods = 5'd16;
      3'h7:    acq_periods = 5'd20;
      default: acq_periods = 5'd0;
    endcase
  endfunction

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel[1:0] == adcseq_pkg::CLK_RC_CODE);
  endfunction

  // rc clock, comparator and pins come from other domains
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rc_meta_ff  <= 1'b0;
      rc_sync_ff  <= 1'b0;
      rc_last_ff  <= 1'b0;
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
      pin_meta_ff <= 8'h00;
      pin_sync_ff <= 8'h00;
    end else begin
      rc_meta_ff  <= i_internal_rc_clock;
      rc_sync_ff  <= rc_meta_ff;
      rc_last_ff  <= rc_sync_ff;
      cmp_meta_ff <= i_comparator;
      cmp_sync_ff <= cmp_meta_ff;
      pin_meta_ff <= i_port_pins;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // free-running divider; a select change only skews the current period
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt_ff <= 7'd0;
    end else if (div_cnt_ff >=
                 clk_div_periods(i_conversion_clock_select) - 7'd1) begin
      div_cnt_ff <= 7'd0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 7'd1;
    end
  end

  assign tad_tick = is_rc(i_conversion_clock_select) ?
                    (rc_sync_ff & ~rc_last_ff) :
                    (div_cnt_ff >=
                     clk_div_periods(i_conversion_clock_select) - 7'd1);

  // trigger only counts while the converter is on
  assign start_req = i_converter_on_bit &
                     (i_start_set | i_special_trigger);
  assign busy      = (state_ff == adcseq_pkg::ST_ACQUIRE) ||
                     (state_ff == adcseq_pkg::ST_DELAY) ||
                     (state_ff == adcseq_pkg::ST_CONVERT);
  assign conv_done = (state_ff == adcseq_pkg::ST_CONVERT) && tad_tick &&
                     (phase_cnt_ff == adcseq_pkg::CONV_PERIODS - 5'd1);
  assign abort     = busy && go_ff && i_start_clear && !conv_done;
  assign sar_decided = cmp_sync_ff ? sar_ff : (sar_ff & ~mask_ff);

  // start flag: set by software or trigger, cleared by software or done
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      go_ff <= 1'b0;
    end else if (!i_converter_on_bit) begin
      go_ff <= 1'b0;
    end else if (conv_done) begin
      go_ff <= 1'b0;
    end else if (i_start_clear) begin
      go_ff <= 1'b0;
    end else if (start_req) begin
      go_ff <= 1'b1;
    end
  end

  // completion flag; a new completion wins over a clear
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      complete_ff <= 1'b0;
    end else if (conv_done) begin
      complete_ff <= 1'b1;
    end else if (i_complete_clear) begin
      complete_ff <= 1'b0;
    end
  end

  // sequencer; acquire and convert are invisible outside, only go shows
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff     <= adcseq_pkg::ST_OFF;
      phase_cnt_ff <= 5'd0;
      delay_cnt_ff <= 3'd0;
    end else if (!i_converter_on_bit) begin
      state_ff     <= adcseq_pkg::ST_OFF;
      phase_cnt_ff <= 5'd0;
    end else if (abort) begin
      state_ff     <= adcseq_pkg::ST_HOLDOFF;
      phase_cnt_ff <= 5'd0;
    end else begin
      case (state_ff)
        adcseq_pkg::ST_OFF: begin
          state_ff     <= adcseq_pkg::ST_DISCHARGE;
          phase_cnt_ff <= 5'd0;
        end
        adcseq_pkg::ST_DISCHARGE: begin
          if (tad_tick) begin
            if (phase_cnt_ff == adcseq_pkg::DISCHARGE_PERIODS - 5'd1) begin
              state_ff     <= adcseq_pkg::ST_SAMPLE;
              phase_cnt_ff <= 5'd0;
            end else begin
              phase_cnt_ff <= phase_cnt_ff + 5'd1;
            end
          end
        end
        adcseq_pkg::ST_SAMPLE: begin
          if (go_ff || start_req) begin
            phase_cnt_ff <= 5'd0;
            delay_cnt_ff <= 3'd0;
            if (i_acquisition_time_select == adcseq_pkg::ACQ_MANUAL) begin
              state_ff <= adcseq_pkg::ST_DELAY;
            end else begin
              state_ff <= adcseq_pkg::ST_ACQUIRE;
            end
          end
        end
        adcseq_pkg::ST_ACQUIRE: begin
          if (tad_tick) begin
            if (phase_cnt_ff >=
                acq_periods(i_acquisition_time_select) - 5'd1) begin
              state_ff     <= adcseq_pkg::ST_CONVERT;
              phase_cnt_ff <= 5'd0;
            end else begin
              phase_cnt_ff <= phase_cnt_ff + 5'd1;
            end
          end
        end
        adcseq_pkg::ST_DELAY: begin
          // lets a sleep instruction execute before the array disconnects
          if (delay_cnt_ff == adcseq_pkg::INSTR_CLOCKS - 3'd1) begin
            state_ff     <= adcseq_pkg::ST_CONVERT;
            phase_cnt_ff <= 5'd0;
          end else begin
            delay_cnt_ff <= delay_cnt_ff + 3'd1;
          end
        end
        adcseq_pkg::ST_CONVERT: begin
          if (tad_tick) begin
            if (conv_done) begin
              state_ff     <= adcseq_pkg::ST_HOLDOFF;
              phase_cnt_ff <= 5'd0;
            end else begin
              phase_cnt_ff <= phase_cnt_ff + 5'd1;
            end
          end
        end
        adcseq_pkg::ST_HOLDOFF: begin
          if (tad_tick) begin
            if (phase_cnt_ff == adcseq_pkg::HOLDOFF_PERIODS - 5'd1) begin
              state_ff     <= adcseq_pkg::ST_DISCHARGE;
              phase_cnt_ff <= 5'd0;
            end else begin
              phase_cnt_ff <= phase_cnt_ff + 5'd1;
            end
          end
        end
        default: begin
          state_ff     <= adcseq_pkg::ST_OFF;
          phase_cnt_ff <= 5'd0;
        end
      endcase
    end
  end

  // successive approximation: first period disconnects, ten decide bits
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sar_ff  <= 10'h000;
      mask_ff <= 10'h000;
    end else if (state_ff != adcseq_pkg::ST_CONVERT) begin
      sar_ff  <= adcseq_pkg::SAR_FIRST_TRIAL;
      mask_ff <= adcseq_pkg::SAR_FIRST_TRIAL;
    end else if (tad_tick && phase_cnt_ff != 5'd0) begin
      sar_ff  <= sar_decided | (mask_ff >> 1);
      mask_ff <= mask_ff >> 1;
    end
  end

  // result changes only on completion or a software write
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      result_ff <= adcseq_pkg::RESULT_RESET;
    end else if (conv_done) begin
      result_ff <= sar_decided;
    end else if (i_result_write) begin
      result_ff <= i_result_wdata;
    end
  end

  // strap is caught on the first edge after reset release
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_loaded_ff <= 1'b0;
      port_cfg_ff   <= adcseq_pkg::PORT_CFG_DIGITAL;
    end else if (!cfg_loaded_ff) begin
      cfg_loaded_ff <= 1'b1;
      port_cfg_ff   <= i_portb_analog_reset_select ?
                       adcseq_pkg::PORT_CFG_ANALOG :
                       adcseq_pkg::PORT_CFG_DIGITAL;
    end else if (i_port_cfg_write) begin
      port_cfg_ff   <= i_port_cfg_wdata;
    end
  end

  // channel follows select with no regard to pin direction
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_read_ff <= 8'h00;
      channel_ff   <= 4'h0;
    end else begin
      port_read_ff <= pin_sync_ff & ~port_cfg_ff;
      channel_ff   <= i_channel_select;
    end
  end

  assign o_start_flag               = go_ff;
  assign o_conversion_complete_flag = complete_ff;
  assign o_result_high_reg          = {6'h00, result_ff[9:8]};
  assign o_result_low_reg           = result_ff[7:0];
  assign o_port_analog_config_bits  = port_cfg_ff;
  assign o_port_read                = port_read_ff;
  assign o_mux_channel              = channel_ff;
  assign o_sample_switch            = (state_ff == adcseq_pkg::ST_SAMPLE) ||
                                      (state_ff == adcseq_pkg::ST_ACQUIRE) ||
                                      (state_ff == adcseq_pkg::ST_DELAY);
  assign o_discharge                = (state_ff == adcseq_pkg::ST_DISCHARGE);
  assign o_dac_code                 = sar_ff;

  // assertion helper: bit periods already seen in the current state visit
  adcseq_pkg::adcseq_state_type seen_state_ff;
  logic [4:0] seen_ticks_ff;
  logic [4:0] visit_ticks;

  assign visit_ticks = (state_ff == seen_state_ff) ? seen_ticks_ff : 5'd0;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen_state_ff <= adcseq_pkg::ST_OFF;
      seen_ticks_ff <= 5'd0;
    end else begin
      seen_state_ff <= state_ff;
      seen_ticks_ff <= visit_ticks + {4'd0, tad_tick};
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  AST_TRIGGER_OFF: assert property (
    !i_converter_on_bit |=> !go_ff)
    else $error("start flag set while converter off");
  AST_MANUAL_DELAY: assert property (
    state_ff == adcseq_pkg::ST_SAMPLE && (go_ff || start_req) &&
    i_acquisition_time_select == adcseq_pkg::ACQ_MANUAL &&
    i_converter_on_bit && !i_start_clear
    |=> (state_ff == adcseq_pkg::ST_DELAY)[*4] ##1
        state_ff == adcseq_pkg::ST_CONVERT)
    else $error("manual start not delayed one instruction cycle");
  AST_CONV_LEN: assert property (
    state_ff == adcseq_pkg::ST_CONVERT && tad_tick |->
      conv_done == (visit_ticks == 5'd10))
    else $error("conversion not eleven periods");
  AST_DONE_FLAGS: assert property (
    conv_done |=> !go_ff && complete_ff &&
                  state_ff == adcseq_pkg::ST_HOLDOFF)
    else $error("completion flags wrong");
  AST_ABORT_KEEPS_RESULT: assert property (
    abort && !i_result_write |=> $stable(result_ff) &&
                                 state_ff == adcseq_pkg::ST_HOLDOFF)
    else $error("abort changed result");
  AST_RESULT_LOAD: assert property (
    conv_done |=> result_ff == $past(sar_decided))
    else $error("result not loaded on completion");
  AST_HOLDOFF_EXIT: assert property (
    state_ff == adcseq_pkg::ST_HOLDOFF && tad_tick && i_converter_on_bit
    |=> (state_ff == adcseq_pkg::ST_DISCHARGE) ==
        ($past(visit_ticks) == adcseq_pkg::HOLDOFF_PERIODS - 5'd1))
    else $error("holdoff length wrong");
  AST_DISCHARGE_FIRST: assert property (
    $rose(state_ff == adcseq_pkg::ST_SAMPLE) |->
      $past(state_ff) == adcseq_pkg::ST_DISCHARGE)
    else $error("sample without discharge");
  AST_ACQ_LEN: assert property (
    state_ff == adcseq_pkg::ST_ACQUIRE && tad_tick && i_converter_on_bit &&
    !abort |=> (state_ff == adcseq_pkg::ST_CONVERT) ==
               ($past(visit_ticks) + 5'd1 ==
                acq_periods($past(i_acquisition_time_select))))
    else $error("acquisition period cut short");
  AST_PORT_MASK: assert property (
    ##1 (o_port_read & $past(port_cfg_ff)) == 8'h00)
    else $error("analog pin read as one");

  COV_MANUAL: cover property (
    state_ff == adcseq_pkg::ST_DELAY ##[1:8]
    state_ff == adcseq_pkg::ST_CONVERT);
  COV_AUTO: cover property (
    state_ff == adcseq_pkg::ST_ACQUIRE ##[1:400]
    state_ff == adcseq_pkg::ST_CONVERT);
  COV_DONE: cover property (conv_done);
  COV_ABORT: cover property (abort);

endmodule // adcseq_top

`default_nettype wire

// file: tb/adcseq_analog_model.sv
// analog side model: pin level compared against the trial code, rc clock
`timescale 1ns/1ns
`default_nettype none

module adcseq_analog_model (
  input  wire logic [9:0] i_level,
  input  wire logic [9:0] i_dac_code,
  output logic            o_comparator,
  output logic            o_rc_clock
);
  // rc period fixed at 900 ns so the bench can predict bit periods
  initial begin
    o_rc_clock = 1'b0;
    #13;
    forever #450 o_rc_clock = ~o_rc_clock;
  end

  // whatever level sits on the pin is what gets converted
  assign o_comparator = (i_level >= i_dac_code);

endmodule // adcseq_analog_model

`default_nettype wire

// file: tb/adc_acquisition_sequencer_tb.sv
// self-checking bench for the converter acquisition sequencer
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) \
  checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
  end

module adc_acquisition_sequencer_tb;
  logic       clk, arst_n, on, sset, sclr, trig, cclr, rwr, strap, cfgwr;
  logic [2:0] acq, csel;
  logic [3:0] chan, mux;
  logic [9:0] rwd, level, dac;
  logic [7:0] cfgwd, pins, res_hi, res_lo, cfg, pread;
  logic       start_f, done_f, samp, dis, rc, cmp;
  int         errors, checks;

  adcseq_top i_dut (
    .i_clock(clk), .i_arst_n(arst_n), .i_converter_on_bit(on),
    .i_start_set(sset), .i_start_clear(sclr), .i_special_trigger(trig),
    .i_acquisition_time_select(acq), .i_conversion_clock_select(csel),
    .i_channel_select(chan), .i_internal_rc_clock(rc), .i_comparator(cmp),
    .i_complete_clear(cclr), .i_result_write(rwr), .i_result_wdata(rwd),
    .i_portb_analog_reset_select(strap), .i_port_cfg_write(cfgwr),
    .i_port_cfg_wdata(cfgwd), .i_port_pins(pins), .o_start_flag(start_f),
    .o_conversion_complete_flag(done_f), .o_result_high_reg(res_hi),
    .o_result_low_reg(res_lo), .o_port_analog_config_bits(cfg),
    .o_port_read(pread), .o_mux_channel(mux), .o_sample_switch(samp),
    .o_discharge(dis), .o_dac_code(dac));

  adcseq_analog_model i_model (
    .i_level(level), .i_dac_code(dac), .o_comparator(cmp), .o_rc_clock(rc));

  always #25 clk = ~clk;

  task automatic give_verdict();
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (!(samp && !dis && !start_f) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    `CHK("idle_reached", 1'b1, n < 3000)
  endtask

  // one start with timing measured against the selected bit period
  task automatic run_one(input logic [2:0] cs, input logic [2:0] aq,
                         input int t, input int na);
    int a, c, h;
    csel <= cs;
    acq  <= aq;
    cclr <= 1'b1;
    @(posedge clk);
    cclr <= 1'b0;
    wait_idle();
    sset <= 1'b1;
    @(posedge clk);
    sset <= 1'b0;
    a = 0;
    while (samp && a < 3000) begin
      @(posedge clk);
      a++;
    end
    if (na == 0) begin
      `CHK("manual_delay", 1'b1, a >= 4 && a <= 6)
    end else begin
      `CHK("acq_len", 1'b1, a >= (na-1)*t+1 && a <= na*t+2)
    end
    c = 0;
    while (!done_f && c < 3000) begin
      @(posedge clk);
      c++;
    end
    if (na == 0) begin
      `CHK("conv_len_m", 1'b1, c >= 10*t && c <= 11*t+1)
    end else begin
      `CHK("conv_len", 1'b1, c >= 11*t-1 && c <= 11*t+1)
    end
    `CHK("start_cleared", 1'b0, start_f)
    if (t >= 16) begin
      `CHK("res_hi", {6'h00, level[9:8]}, res_hi)
      `CHK("res_lo", level[7:0], res_lo)
    end
    h = 0;
    while (!dis && h < 3000) begin
      @(posedge clk);
      h++;
    end
    `CHK("holdoff", 1'b1, h >= 2*t-1 && h <= 2*t+1)
    wait_idle();
    `CHK("mux", chan, mux)
    `CHK("dac_idle", adcseq_pkg::SAR_FIRST_TRIAL, dac)
  endtask

  task automatic test_codes();
    logic [2:0] cs [7] = '{3'b000, 3'b100, 3'b001, 3'b101,
                           3'b010, 3'b110, 3'b111};
    int tt [7] = '{2, 4, 8, 16, 32, 64, 18};
    int nn [7] = '{2, 4, 6, 8, 12, 16, 20};
    for (int i = 0; i < 7; i++) begin
      run_one(cs[i], 3'(i+1), tt[i], nn[i]);
    end
    level <= 10'h1A7;
    run_one(3'b101, 3'b000, 16, 0);
  endtask

  task automatic test_abort();
    csel  <= 3'b110;
    acq   <= 3'b000;
    rwr   <= 1'b1;
    rwd   <= 10'h2A5;
    cclr  <= 1'b1;
    @(posedge clk);
    rwr   <= 1'b0;
    cclr  <= 1'b0;
    wait_idle();
    sset  <= 1'b1;
    @(posedge clk);
    sset  <= 1'b0;
    repeat (120) @(posedge clk);
    sclr  <= 1'b1;
    @(posedge clk);
    sclr  <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("abort_start", 1'b0, start_f)
    `CHK("abort_res", 10'h2A5, {res_hi[1:0], res_lo})
    wait_idle();
    `CHK("abort_flag", 1'b0, done_f)
  endtask

  task automatic test_misc();
    cfgwr <= 1'b1;
    cfgwd <= 8'h0F;
    pins  <= 8'h3C;
    chan  <= 4'h5;
    @(posedge clk);
    cfgwr <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("port_read", 8'h30, pread)
    `CHK("mux_chan", 4'h5, mux)
    on    <= 1'b0;
    trig  <= 1'b1;
    @(posedge clk);
    trig  <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("trig_off", 1'b0, start_f)
    on    <= 1'b1;
    csel  <= 3'b000;
    repeat (2) @(posedge clk);
    wait_idle();
    trig  <= 1'b1;
    @(posedge clk);
    trig  <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("trig_on", 1'b1, start_f)
    strap <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    `CHK("rst_start", 1'b0, start_f)
    `CHK("rst_samp", 1'b0, samp)
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("strap_dig", 8'h00, cfg)
  endtask

  initial begin
    clk = 0; arst_n = 0; on = 1; sset = 0; sclr = 0; trig = 0;
    cclr = 0; rwr = 0; rwd = 0; strap = 1; cfgwr = 0; cfgwd = 0;
    pins = 0; acq = 0; csel = 0; chan = 4'h9; level = 10'h2C3;
    errors = 0; checks = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("strap_ana", 8'hFF, cfg)
    `CHK("rst_done", 1'b0, done_f)
    test_codes();
    test_abort();
    test_misc();
    give_verdict();
  end

  // the longest pass needs well under 40000 cycles
  initial begin
    #2000000;
    errors++;
    give_verdict();
  end

endmodule // adc_acquisition_sequencer_tb

`default_nettype wire
